//--- throttle_params.svh
`ifndef THROTTLE_PARAMS_SVH
`define THROTTLE_PARAMS_SVH
// closed-loop throttle window length in core clocks, global window lengths in throttle windows
`define TW_LAST        11'd1343
`define GW_NORM_LAST   14'd16383
`define GW_SHORT_LAST  14'd3
`define CLEAN_NORM     5'd16
`define CLEAN_SHORT    5'd2
`define STAIR_STEP     8'h02
// configuration ring completion time for a register write
`define RING_LAST      6'd39
// register byte offsets
`define OFF_CTRL       8'h00
`define OFF_LIMITS     8'h04
`define OFF_GBL        8'h08
`define OFF_STATUS     8'h0c
// control field positions
`define CTL_CLOSED     0
`define CTL_HOTRESP    1
`define CTL_SHORT      2
// reset values and bus response codes
`define LOW_RST        8'h00
`define MID_RST        8'h00
`define HI_RST         8'h00
`define GBL_RST        8'h00
`define RESP_OK        2'b00
`define RESP_ERR       2'b10
`endif

//--- throttle_pkg.sv
`include "throttle_params.svh"
package throttle_pkg;
    // which preset feeds the active limit of a branch
    typedef enum logic [1:0] {
        SEL_LOW   = 2'b00,
        SEL_MID   = 2'b01,
        SEL_HIGH  = 2'b10,
        SEL_STAIR = 2'b11
    } sel_t;

    typedef struct packed {
        logic [10:0]            tw_cnt;
        logic [13:0]            gw_cnt;
        logic [1:0][3:0][9:0]   pair_win;
        logic [1:0][3:0][23:0]  pair_glb;
        logic [1:0]             over;
        logic [1:0]             flag;
        logic [1:0][4:0]        clean;
        sel_t [1:0]             sel;
        logic [1:0][7:0]        act_lim;
        logic [2:0]             ctrl;
        logic [7:0]             low;
        logic [7:0]             mid;
        logic [7:0]             hi;
        logic [7:0]             gbl;
        logic                   aw_have;
        logic                   w_have;
        logic [7:0]             waddr;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   wbusy;
        logic [5:0]             wcnt;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } state_t;
endpackage

//--- activation_throttle.sv
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "throttle_params.svh"
// Operation
// - any DIMM at/above low, all below mid: load mid-level limit
// - limit 0 is unlimited; N allows 4N activates per throttle window
// - global window is whole multiple of the 1344-clock throttle window
// - normal global window is 16384 throttle windows
// - short-window select makes global window 4 throttle windows
// - count activates per DIMM pair per branch in 24-bit counters
// - pair count above global limit sets branch flag; flag forces mid
// - flag clears after 16 clean global windows in a row
// - short-window select needs only 2 clean windows
// - new excess restarts the clean-window count at mid level
// - all windows are timed in core clocks
// - a throttle register write takes about 40 core clocks
// - new low or mid values act at once; flag period goes on
// - below low threshold with flag clear: low-level limit
// - closed-loop select clear: only the flag picks low or mid
// - staircase: further rise lowers limit by 2, never below high
// - step mode: above mid threshold applies high-level limit
module activation_throttle
    import throttle_pkg::*;
(
    input  wire logic                 ref_clk_i,
    input  wire logic                 resetn_i,
    input  wire logic [7:0]           s_axi_awaddr_i,
    input  wire logic                 s_axi_awvalid_i,
    output logic                      s_axi_awready_o,
    input  wire logic [31:0]          s_axi_wdata_i,
    input  wire logic [3:0]           s_axi_wstrb_i,
    input  wire logic                 s_axi_wvalid_i,
    output logic                      s_axi_wready_o,
    output logic [1:0]                s_axi_bresp_o,
    output logic                      s_axi_bvalid_o,
    input  wire logic                 s_axi_bready_i,
    input  wire logic [7:0]           s_axi_araddr_i,
    input  wire logic                 s_axi_arvalid_i,
    output logic                      s_axi_arready_o,
    output logic [31:0]               s_axi_rdata_o,
    output logic [1:0]                s_axi_rresp_o,
    output logic                      s_axi_rvalid_o,
    input  wire logic                 s_axi_rready_i,
    input  wire logic [1:0]           temp_above_low_i,
    input  wire logic [1:0]           temp_above_mid_i,
    input  wire logic [1:0]           temp_rising_i,
    input  wire logic [1:0][3:0]      act_req_i,
    output logic [1:0][3:0]           act_block_o,
    output logic [1:0][7:0]           active_activation_limit_o,
    output logic [1:0]                global_throttle_flag_o
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // limit N allows 4N activates; zero never blocks
    function automatic logic at_limit(input logic [9:0] cnt,
                                      input logic [7:0] lim);
        at_limit = (lim != 8'h00) && (cnt >= {lim, 2'b00});
    endfunction

    function automatic logic [7:0] merge8(input logic [7:0] old,
                                          input logic [7:0] nw,
                                          input logic       en);
        merge8 = en ? nw : old;
    endfunction

    state_t q;
    state_t d;

    logic                   tw_end;
    logic                   gw_end;
    logic [1:0]             over_now;
    logic [1:0]             flag_now;
    logic [1:0][3:0]        act_go;
    logic [4:0]             clean_need;
    logic [13:0]            gw_last;
    logic [7:0]             stair_val;
    logic                   wr_go;
    logic                   rd_go;

    // ****************************************************************
    // window timing and activate counting
    // ****************************************************************
    // windows run on the core clock only, so limits read in core clocks
    always_comb begin
        gw_last  = q.ctrl[`CTL_SHORT] ? `GW_SHORT_LAST : `GW_NORM_LAST;
        tw_end   = (q.tw_cnt == `TW_LAST);
        gw_end   = tw_end && (q.gw_cnt >= gw_last);
        clean_need = q.ctrl[`CTL_SHORT] ? `CLEAN_SHORT
                                        : `CLEAN_NORM;
        for (int b = 0; b < 2; b++) begin
            over_now[b] = q.over[b];
            for (int p = 0; p < 4; p++) begin
                act_block_o[b][p] = at_limit(q.pair_win[b][p],
                                             q.act_lim[b]);
                act_go[b][p] = act_req_i[b][p] && !act_block_o[b][p];
                if (q.gbl != 8'h00 &&
                    q.pair_glb[b][p] > {q.gbl, 16'h0000}) begin
                    over_now[b] = 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // global flag, limit selection, register file and bus
    // ****************************************************************
    always_comb begin
        d = q;
        flag_now = q.flag;
        stair_val = 8'h00;
        wr_go = 1'b0;
        rd_go = 1'b0;
        // throttle window and global window counters
        d.tw_cnt = tw_end ? 11'd0 : q.tw_cnt + 11'd1;
        if (gw_end) begin
            d.gw_cnt = 14'd0;
        end else if (tw_end) begin
            d.gw_cnt = q.gw_cnt + 14'd1;
        end
        for (int b = 0; b < 2; b++) begin
            for (int p = 0; p < 4; p++) begin
                if (tw_end) begin
                    d.pair_win[b][p] = 10'd0;
                end else if (act_go[b][p] && q.pair_win[b][p] != 10'h3ff) begin
                    d.pair_win[b][p] = q.pair_win[b][p] + 10'd1;
                end
                if (gw_end) begin
                    d.pair_glb[b][p] = 24'd0;
                end else if (act_go[b][p] &&
                             q.pair_glb[b][p] != 24'hffffff) begin
                    d.pair_glb[b][p] = q.pair_glb[b][p] + 24'd1;
                end
            end
            d.over[b] = gw_end ? 1'b0 : over_now[b];
            // flag outcome of this window, used at once by selection
            if (gw_end) begin
                if (over_now[b]) begin
                    flag_now[b] = 1'b1;
                    d.clean[b] = 5'd0;
                end else if (q.flag[b]) begin
                    if (q.clean[b] + 5'd1 >= clean_need) begin
                        flag_now[b] = 1'b0;
                        d.clean[b] = 5'd0;
                    end else begin
                        d.clean[b] = q.clean[b] + 5'd1;
                    end
                end
            end
            d.flag[b] = flag_now[b];
            // preset choice is redone only when the global window expires
            if (gw_end) begin
                if (!q.ctrl[`CTL_CLOSED]) begin
                    d.sel[b] = flag_now[b] ? SEL_MID : SEL_LOW;
                end else if (temp_above_mid_i[b]) begin
                    if (q.ctrl[`CTL_HOTRESP]) begin
                        d.sel[b] = SEL_HIGH;
                    end else if (q.act_lim[b] > q.mid) begin
                        d.sel[b] = SEL_MID;
                    end else begin
                        d.sel[b] = SEL_STAIR;
                    end
                end else if (temp_above_low_i[b]) begin
                    d.sel[b] = SEL_MID;
                end else begin
                    d.sel[b] = flag_now[b] ? SEL_MID : SEL_LOW;
                end
            end
            // presets are read live so rewrites act at once
            unique case (d.sel[b])
                SEL_LOW:   d.act_lim[b] = q.low;
                SEL_MID:   d.act_lim[b] = q.mid;
                SEL_HIGH:  d.act_lim[b] = q.hi;
                SEL_STAIR: begin
                    stair_val = q.act_lim[b];
                    if (gw_end && q.sel[b] == SEL_STAIR &&
                        temp_rising_i[b]) begin
                        stair_val = q.act_lim[b] - `STAIR_STEP;
                        if (q.act_lim[b] < `STAIR_STEP) begin
                            stair_val = 8'h00;
                        end
                    end
                    // never below the high-level floor
                    d.act_lim[b] = (stair_val < q.hi) ? q.hi
                                                      : stair_val;
                end
            endcase
        end
        // write address and data taken in either order
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            d.aw_have = 1'b1;
            d.waddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            d.w_have = 1'b1;
            d.wdata = s_axi_wdata_i;
            d.wstrb = s_axi_wstrb_i;
        end
        // write travels the configuration ring before it lands
        if (q.aw_have && q.w_have && !q.wbusy && !q.bvalid) begin
            d.wbusy = 1'b1;
            d.wcnt = 6'd0;
        end
        if (q.wbusy) begin
            d.wcnt = q.wcnt + 6'd1;
            wr_go = (q.wcnt == `RING_LAST);
        end
        if (wr_go) begin
            d.wbusy = 1'b0;
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `RESP_OK;
            unique case (q.waddr)
                `OFF_CTRL: begin
                    if (q.wstrb[0]) begin
                        d.ctrl = q.wdata[2:0];
                    end
                end
                `OFF_LIMITS: begin
                    d.low = merge8(q.low, q.wdata[7:0], q.wstrb[0]);
                    d.mid = merge8(q.mid, q.wdata[15:8], q.wstrb[1]);
                    d.hi  = merge8(q.hi, q.wdata[23:16], q.wstrb[2]);
                end
                `OFF_GBL: begin
                    d.gbl = merge8(q.gbl, q.wdata[7:0], q.wstrb[0]);
                end
                `OFF_STATUS: ;
                default: d.bresp = `RESP_ERR;
            endcase
        end
        if (q.bvalid && s_axi_bready_i) begin
            d.bvalid = 1'b0;
        end
        // read answers one cycle after the address is taken
        rd_go = s_axi_arvalid_i && s_axi_arready_o;
        if (rd_go) begin
            d.rvalid = 1'b1;
            d.rresp = `RESP_OK;
            unique case (s_axi_araddr_i)
                `OFF_CTRL:   d.rdata = {29'd0, q.ctrl};
                `OFF_LIMITS: d.rdata = {8'h00, q.hi, q.mid, q.low};
                `OFF_GBL:    d.rdata = {24'd0, q.gbl};
                `OFF_STATUS: d.rdata = {8'h00, q.act_lim, 6'd0, q.flag};
                default: begin
                    d.rdata = 32'h00000000;
                    d.rresp = `RESP_ERR;
                end
            endcase
        end else if (q.rvalid && s_axi_rready_i) begin
            d.rvalid = 1'b0;
        end
    end

    // ready only while the slot is empty; one write in flight at a time
    assign s_axi_awready_o = !q.aw_have;
    assign s_axi_wready_o  = !q.w_have;
    assign s_axi_arready_o = !q.rvalid;
    assign s_axi_bvalid_o  = q.bvalid;
    assign s_axi_bresp_o   = q.bresp;
    assign s_axi_rvalid_o  = q.rvalid;
    assign s_axi_rdata_o   = q.rdata;
    assign s_axi_rresp_o   = q.rresp;
    assign active_activation_limit_o = q.act_lim;
    assign global_throttle_flag_o    = q.flag;

    // state register
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.low <= `LOW_RST;
            q.mid <= `MID_RST;
            q.hi  <= `HI_RST;
            q.gbl <= `GBL_RST;
            q.sel <= {SEL_LOW, SEL_LOW};
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_tw_wrap: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        q.tw_cnt == `TW_LAST |=> q.tw_cnt == 11'd0)
        else $error("throttle window did not wrap at its end");
    a_short_window: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        q.ctrl[`CTL_SHORT] && tw_end |=> q.gw_cnt <= `GW_SHORT_LAST)
        else $error("short global window ran past four windows");
    a_norm_window: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        gw_end |-> q.tw_cnt == `TW_LAST)
        else $error("global window ended off a throttle boundary");
    a_flag_set: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        gw_end && over_now[0] |=> q.flag[0] && q.clean[0] == 5'd0)
        else $error("excess did not set the global flag");
    a_flag_restart: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        q.flag[1] && gw_end && over_now[1] |=> q.clean[1] == 5'd0)
        else $error("excess did not restart the clean count");
    a_clean_bound: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        q.clean[0] < `CLEAN_NORM)
        else $error("clean count passed its limit");
    a_block_limit: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        act_block_o[0][0] |=> q.pair_win[0][0] == $past(q.pair_win[0][0])
            || q.pair_win[0][0] == 10'd0)
        else $error("blocked pair still counted an activate");
    a_stair_floor: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        q.sel[0] == SEL_STAIR |-> q.act_lim[0] >= $past(q.hi))
        else $error("staircase went below the high-level limit");
    a_step_high: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        gw_end && q.ctrl[`CTL_CLOSED] && q.ctrl[`CTL_HOTRESP] &&
            temp_above_mid_i[0] |=> q.act_lim[0] == $past(q.hi))
        else $error("step mode did not apply the high-level limit");
    a_open_loop: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        gw_end && !q.ctrl[`CTL_CLOSED] |=> q.sel[0] ==
            ($past(flag_now[0]) ? SEL_MID : SEL_LOW))
        else $error("open loop chose the wrong preset");
    a_ring_delay: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        $rose(q.wbusy) |-> !q.bvalid [*8])
        else $error("write answered before the ring delay");

endmodule // activation_throttle

//--- dimm_pair_model.sv
`timescale 1ns/10ps
// ************************************************************
// buffered dimm pair traffic source
// ************************************************************
module dimm_pair_model (
    input  wire logic           ref_clk_i,
    input  wire logic           resetn_i,
    input  wire logic           burst_i,
    output logic [1:0][3:0]     act_req_o
);
    // requests keep coming while blocked, as a real command queue does
    // pair 0 of branch 0 asks every cycle in burst so the block must act
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            act_req_o <= 8'h00;
        end else begin
            act_req_o       <= 8'($urandom);
            act_req_o[0][0] <= burst_i | 1'($urandom);
        end
    end
endmodule // dimm_pair_model

//--- tb_top.sv
`timescale 1ns/10ps
`include "throttle_params.svh"
// ************************************************************
// bench top
// ************************************************************
module tb_top;
    logic             clk, rst_n, burst, mon_en, pblk, seen, any_blk;
    logic [7:0]       awaddr, araddr, lo, mon_lim, ex;
    logic             awvalid, awready, wvalid, wready, bvalid, bready;
    logic             arvalid, arready, rvalid, rready;
    logic [31:0]      wdata, rdata;
    logic [3:0]       wstrb;
    logic [1:0]       bresp, rresp, t_low, t_mid, t_rise, gflag;
    logic [1:0][3:0]  act_req, act_blk;
    logic [1:0][7:0]  act_lim;
    int               err_total, comparisons, cyc, acc, ticks;

    activation_throttle i_activation_throttle (
        .ref_clk_i(clk), .resetn_i(rst_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .temp_above_low_i(t_low),
        .temp_above_mid_i(t_mid), .temp_rising_i(t_rise),
        .act_req_i(act_req), .act_block_o(act_blk),
        .active_activation_limit_o(act_lim),
        .global_throttle_flag_o(gflag));

    dimm_pair_model i_dimm_pair_model (
        .ref_clk_i(clk), .resetn_i(rst_n),
        .burst_i(burst), .act_req_o(act_req));

    // 20 mhz core clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // staircase step, floored at the high-level limit
    function automatic logic [7:0] stair(input logic [7:0] c,
                                         input logic [7:0] h);
        return (c < h + 8'h02) ? h : c - 8'h02;
    endfunction

    function automatic logic [31:0] lims(input logic [7:0] l, m, h);
        return {8'h00, h, m, l};
    endfunction

    task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
        comparisons = comparisons + 1;
        if (seen_v !== exp_v) begin
            err_total = err_total + 1;
            $display("FAIL %0t seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask

    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one write at a time; handshakes sampled mid-cycle, acted on at edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int   n;
        logic ah, wh, bh;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        n = -1000;
        bh = 1'b0;
        while (!bh) begin
            @(negedge clk);
            n = n + 1;
            ah = awvalid & awready;
            wh = wvalid & wready;
            bh = bvalid;
            if ((ah || !awvalid) && (wh || !wvalid) && (ah || wh)) n = 0;
            if (bh) chk(32'(bresp), 32'(er));
            if (bh) chk(32'(n >= 41 && n <= 44), 32'h1);
            @(posedge clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        repeat (80) @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        logic        ah, rh;
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        rh = 1'b0;
        while (!rh) begin
            @(negedge clk);
            ah = arvalid & arready;
            rh = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ah) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk(d, ed);
        chk(32'(r), 32'(er));
    endtask

    // wait, bounded, for the limit of branch b to move
    task automatic wait_chg(input int b, input int lim);
        logic [7:0] o;
        int         n;
        o = act_lim[b];
        n = 0;
        while (act_lim[b] === o && n < lim) begin
            @(negedge clk);
            n = n + 1;
        end
        @(negedge clk);
    endtask

    // hang guard: the planned run needs about 60k cycles
    always @(posedge clk) begin
        ticks <= ticks + 1;
        if (ticks == 95000) begin
            err_total = err_total + 1;
            end_sim();
        end
    end

    // throttle window watch on branch 0 pair 0, sampled mid-cycle
    always @(negedge clk) begin
        any_blk = any_blk | act_blk[0][0];
        if (mon_en) begin
            cyc = cyc + 1;
            if (!act_blk[0][0] && pblk) begin
                if (seen) chk(32'(cyc), 32'd1344);
                seen = 1'b1;
                cyc = 0;
                acc = 0;
            end
            if (act_blk[0][0] && !pblk && seen) begin
                chk(32'(acc), 32'(4 * mon_lim));
            end
            if (act_req[0][0] && !act_blk[0][0]) acc = acc + 1;
        end
        pblk = act_blk[0][0];
    end

    // ********************************************************
    // main sequence
    // ********************************************************
    initial begin
        void'($urandom(32'h24d896c9));
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {burst, mon_en, pblk, seen, any_blk} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        {t_low, t_mid, t_rise} = 6'h00;
        {err_total, comparisons, ticks, cyc, acc} = 160'h0;
        mon_lim = 8'h00;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk(32'(act_lim), 32'h0);
        chk(32'({gflag, act_blk}), 32'h0);
        rd(`OFF_STATUS, 32'h0, `RESP_OK);
        rd(8'h10, 32'h0, `RESP_ERR);
        wr(8'h14, 32'hffffffff, `RESP_ERR);
        wr(`OFF_CTRL, 32'h4, `RESP_OK);
        lo = 8'h01 + 8'($urandom % 6);
        wr(`OFF_LIMITS, lims(lo, 8'h05, 8'h01), `RESP_OK);
        wr(`OFF_GBL, 32'h1, `RESP_OK);
        rd(`OFF_LIMITS, lims(lo, 8'h05, 8'h01), `RESP_OK);
        wait_chg(0, 5500);
        chk(32'(act_lim), 32'({lo, lo}));
        // a new low value acts long before the next global window ends
        wr(`OFF_LIMITS, lims(lo + 8'h01, 8'h05, 8'h01), `RESP_OK);
        chk(32'(act_lim[0]), 32'(lo + 8'h01));
        mon_lim = lo + 8'h01;
        burst <= 1'b1;
        mon_en = 1'b1;
        repeat (4100) @(posedge clk);
        mon_en = 1'b0;
        wr(`OFF_LIMITS, lims(8'h00, 8'h05, 8'h01), `RESP_OK);
        repeat (1400) @(posedge clk);
        any_blk = 1'b0;
        repeat (2700) @(posedge clk);
        chk(32'(any_blk), 32'h0);
        // a short window holds too few activates to pass the global limit
        chk(32'(gflag), 32'h0);
        wr(`OFF_CTRL, 32'h5, `RESP_OK);
        wr(`OFF_LIMITS, lims(8'h02, 8'h06, 8'h01), `RESP_OK);
        t_low <= 2'b01;
        wait_chg(0, 5500);
        chk(32'(act_lim), 32'({8'h02, 8'h06}));
        wr(`OFF_CTRL, 32'h7, `RESP_OK);
        t_mid <= 2'b01;
        wait_chg(0, 5500);
        chk(32'(act_lim), 32'({8'h02, 8'h01}));
        wr(`OFF_CTRL, 32'h5, `RESP_OK);
        t_mid <= 2'b00;
        wait_chg(0, 5500);
        chk(32'(act_lim[0]), 32'h6);
        t_mid <= 2'b01;
        t_rise <= 2'b01;
        ex = 8'h06;
        for (int i = 0; i < 3; i++) begin
            ex = stair(ex, 8'h01);
            wait_chg(0, 11000);
            chk(32'(act_lim[0]), 32'(ex));
        end
        repeat (5500) @(posedge clk);
        chk(32'(act_lim[0]), 32'h1);
        wr(`OFF_CTRL, 32'h4, `RESP_OK);
        wait_chg(0, 5500);
        chk(32'(act_lim), 32'({8'h02, 8'h02}));
        end_sim();
    end
endmodule // tb_top
